// ==== inc/irqc_regs.vh ====
// Register addresses, bit positions, reset values and vector codes of the interrupt flag block
`ifndef IRQC_REGS_VH
`define IRQC_REGS_VH

// Nibble addresses on the RAM bit port
`define IRQC_ADDR_W 10
`define IRQC_ADDR_CTL0 10'h000
`define IRQC_ADDR_TMR_A 10'h001
`define IRQC_ADDR_TMR_BC 10'h002
`define IRQC_ADDR_TMR_D_CONV 10'h003
`define IRQC_ADDR_CTL22 10'h022
`define IRQC_ADDR_SERIAL 10'h023
`define IRQC_ADDR_EDGE_FIRST 10'h026
`define IRQC_ADDR_EDGE_SECOND 10'h027

// Bit positions inside the nibbles
`define IRQC_BIT_GATE 0
`define IRQC_BIT_F0 2
`define IRQC_BIT_M0 3
`define IRQC_BIT_F1 0
`define IRQC_BIT_M1 1
`define IRQC_BIT_FTA 2
`define IRQC_BIT_MTA 3
`define IRQC_BIT_FTB 0
`define IRQC_BIT_MTB 1
`define IRQC_BIT_FTC 2
`define IRQC_BIT_MTC 3
`define IRQC_BIT_FTD 0
`define IRQC_BIT_MTD 1
`define IRQC_BIT_FAD 2
`define IRQC_BIT_MAD 3
`define IRQC_BIT_F2 0
`define IRQC_BIT_M2 1
`define IRQC_BIT_F3 2
`define IRQC_BIT_M3 3
`define IRQC_BIT_FS 2
`define IRQC_BIT_MS 3

// Reset values
`define IRQC_FLAG_RST 1'b0
`define IRQC_MASK_RST 1'b1
`define IRQC_GATE_RST 1'b0
`define IRQC_EDGE_RST 4'h0

// Edge select codes
`define IRQC_EDGE_NONE 2'h0
`define IRQC_EDGE_FALL 2'h1
`define IRQC_EDGE_RISE 2'h2
`define IRQC_EDGE_BOTH 2'h3

// Vector addresses by priority
`define IRQC_VEC_W 16
`define IRQC_VEC_NONE 16'h0000
`define IRQC_VEC_P1 16'h0002
`define IRQC_VEC_P2 16'h0004
`define IRQC_VEC_P3 16'h0006
`define IRQC_VEC_P4 16'h0008
`define IRQC_VEC_P5 16'h000a
`define IRQC_VEC_P6 16'h000c
`define IRQC_VEC_P7 16'h000e

`endif

// ==== src/irqc_pin_sync.v ====
// Three-stage synchroniser with agreement filter for one external pin
`timescale 1ns/1ns
module irqc_pin_sync #(
  parameter RESET_LEVEL = 1'b1
)
(
  input wire i_clock,      // System clock
  input wire i_reset_n,    // Asynchronous reset, active low
  input wire i_pin,        // Raw pin level
  output reg o_level,      // Filtered level
  output reg o_rise,       // One-cycle pulse on accepted rise
  output reg o_fall        // One-cycle pulse on accepted fall
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // ==========================================================
  // Sync chain; a change counts once stages two and three agree
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      s1_reg <= RESET_LEVEL;
      s2_reg <= RESET_LEVEL;
      s3_reg <= RESET_LEVEL;
      o_level <= RESET_LEVEL;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end
    else
    begin
      s1_reg <= i_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
      if (s2_reg == s3_reg && s3_reg != o_level)
      begin
        o_level <= s3_reg;
        o_rise <= s3_reg;
        o_fall <= ~s3_reg;
      end
    end
  end

endmodule

// ==== src/irqc_prio.v ====
// Priority encoder from the seven request groups to a vector address
`timescale 1ns/1ns
`include "irqc_regs.vh"
module irqc_prio
(
  input wire [6:0] i_group_req,                 // Group requests, bit 0 is priority 1
  output reg [`IRQC_VEC_W-1:0] o_vector         // Vector of the highest pending group
);

  // ==========================================================
  // Lowest index wins
  always @*
  begin
    casez (i_group_req)
      7'b??????1: o_vector = `IRQC_VEC_P1;
      7'b?????10: o_vector = `IRQC_VEC_P2;
      7'b????100: o_vector = `IRQC_VEC_P3;
      7'b???1000: o_vector = `IRQC_VEC_P4;
      7'b??10000: o_vector = `IRQC_VEC_P5;
      7'b?100000: o_vector = `IRQC_VEC_P6;
      7'b1000000: o_vector = `IRQC_VEC_P7;
      default: o_vector = `IRQC_VEC_NONE;
    endcase
  end

endmodule

// ==== src/irqc_top.v ====
// Interrupt request flags, masks, edge selection and priority output
//
// How it works
// - External flags read 0 when idle and 1 once their input requested.
// - External mask 1 blocks its flag's request, 0 passes it.
// - First edge select is four write-only bits at 026, reset to zero.
// - Bits 3:2 pick fourth input edge, 1:0 third; 00 means no detection.
// - Timer A overflow sets timer A flag at 001 bit 2.
// - Timer A mask at 001 bit 3 blocks when 1.
// - Timer B overflow sets timer B flag at 002 bit 0.
// - Timer B mask at 002 bit 1 blocks when 1.
// - Timer C overflow sets timer C flag at 002 bit 2.
// - Timer C mask at 002 bit 3 blocks when 1.
// - Timer D flag at 003 bit 0 set by overflow or capture edge.
// - Timer D mask at 003 bit 1 blocks when 1.
// - Serial flag at 023 bit 2 set on transfer done or suspend.
// - Serial mask at 023 bit 3 blocks when 1.
// - Converter flag at 003 bit 2 set when conversion finishes.
// - Converter mask at 003 bit 3 blocks when 1.
// - Software never sets flags; reset clears gate and flags, sets masks.
// - Request is flag and not mask; CPU sees it only with gate set.
// - Seven priorities; shared vectors for B/third, C/fourth, converter/serial.
// - First two inputs flag on falling edges, others on selected edges.
`timescale 1ns/1ns
`include "irqc_regs.vh"
module irqc_top
(
  input wire i_clock,                        // System clock, 100 MHz
  input wire i_reset_n,                      // MCU reset, active low
  input wire i_ext_line_first_n,             // First external input, falling edge
  input wire i_ext_line_second_n,            // Second external input, falling edge
  input wire i_ext_line_third,               // Third external input
  input wire i_ext_line_fourth,              // Fourth external input
  input wire i_tmr_d_event_input,            // Timer D capture event pin
  input wire i_tmr_d_capture_on,             // Timer D input capture in use
  input wire i_tmr_a_ovf,                    // Timer A overflow pulse
  input wire i_tmr_b_ovf,                    // Timer B overflow pulse
  input wire i_tmr_c_ovf,                    // Timer C overflow pulse
  input wire i_tmr_d_ovf,                    // Timer D overflow pulse
  input wire i_serial_done,                  // Serial transfer completed pulse
  input wire i_serial_suspend,               // Serial transfer suspended pulse
  input wire i_converter_done,               // Conversion finished pulse
  input wire i_irq_taken,                    // CPU accepted an interrupt, clears gate
  input wire i_irq_return,                   // Return from interrupt, sets gate
  input wire [`IRQC_ADDR_W-1:0] i_addr,      // RAM nibble address
  input wire i_wr,                           // Nibble write strobe
  input wire [3:0] i_wdata,                  // Nibble write data
  output reg [3:0] o_rdata,                  // Nibble read data, combinational select registered
  output reg o_irq_req,                      // Request to CPU sequencer
  output reg [`IRQC_VEC_W-1:0] o_irq_vector  // Vector of highest pending source
);

  // ==========================================================
  // State
  reg gate_reg;
  reg [3:0] ext_req_flags_reg;
  reg [3:0] ext_req_masks_reg;
  reg tmr_a_req_flag_reg;
  reg tmr_a_req_mask_reg;
  reg tmr_b_req_flag_reg;
  reg tmr_b_req_mask_reg;
  reg tmr_c_req_flag_reg;
  reg tmr_c_req_mask_reg;
  reg tmr_d_req_flag_reg;
  reg tmr_d_req_mask_reg;
  reg serial_req_flag_reg;
  reg serial_req_mask_reg;
  reg converter_req_flag_reg;
  reg converter_req_mask_reg;
  reg [3:0] edge_select_first_reg;
  reg [3:0] rdata_next;

  wire [3:0] ext_rise;
  wire [3:0] ext_fall;
  wire evt_rise;
  wire evt_fall;
  wire [6:0] group_req;
  wire [`IRQC_VEC_W-1:0] vector_next;

  // ==========================================================
  // Helper functions
  // Edge hit for a two-bit select code
  function edge_hit;
    input [1:0] sel;
    input rise;
    input fall;
    begin
      case (sel)
        `IRQC_EDGE_FALL: edge_hit = fall;
        `IRQC_EDGE_RISE: edge_hit = rise;
        `IRQC_EDGE_BOTH: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  // New flag value: hardware set wins over a software clear
  function flag_upd;
    input cur;
    input set;
    input wr_sel;
    input wbit;
    begin
      flag_upd = set | (cur & ~(wr_sel & ~wbit));
    end
  endfunction

  // Live request of one source: flag set and mask open
  function req_live;
    input flag;
    input mask;
    begin
      req_live = flag & ~mask;
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  irqc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync0
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_ext_line_first_n),
    .o_level(), .o_rise(ext_rise[0]), .o_fall(ext_fall[0])
  );
  irqc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync1
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_ext_line_second_n),
    .o_level(), .o_rise(ext_rise[1]), .o_fall(ext_fall[1])
  );
  irqc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync2
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_ext_line_third),
    .o_level(), .o_rise(ext_rise[2]), .o_fall(ext_fall[2])
  );
  irqc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync3
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_ext_line_fourth),
    .o_level(), .o_rise(ext_rise[3]), .o_fall(ext_fall[3])
  );
  irqc_pin_sync #(.RESET_LEVEL(1'b0)) u_sync_evt
  (
    .i_clock(i_clock), .i_reset_n(i_reset_n), .i_pin(i_tmr_d_event_input),
    .o_level(), .o_rise(evt_rise), .o_fall(evt_fall)
  );

  // ==========================================================
  // Write decode
  wire wr0 = i_wr && i_addr == `IRQC_ADDR_CTL0;
  wire wr1 = i_wr && i_addr == `IRQC_ADDR_TMR_A;
  wire wr2 = i_wr && i_addr == `IRQC_ADDR_TMR_BC;
  wire wr3 = i_wr && i_addr == `IRQC_ADDR_TMR_D_CONV;
  wire wr22 = i_wr && i_addr == `IRQC_ADDR_CTL22;
  wire wr23 = i_wr && i_addr == `IRQC_ADDR_SERIAL;
  wire wr26 = i_wr && i_addr == `IRQC_ADDR_EDGE_FIRST;
  // Second edge select location has no defined bits here, so its writes are dropped

  // ==========================================================
  // Set conditions
  wire set_e0 = ext_fall[0];
  wire set_e1 = ext_fall[1];
  wire set_e2 = edge_hit(edge_select_first_reg[1:0], ext_rise[2], ext_fall[2]);
  wire set_e3 = edge_hit(edge_select_first_reg[3:2], ext_rise[3], ext_fall[3]);
  wire set_td = i_tmr_d_ovf | (i_tmr_d_capture_on & (evt_rise | evt_fall));
  wire set_s = i_serial_done | i_serial_suspend;

  // ==========================================================
  // Flags, masks, gate and edge select
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      gate_reg <= `IRQC_GATE_RST;
      ext_req_flags_reg <= {4{`IRQC_FLAG_RST}};
      ext_req_masks_reg <= {4{`IRQC_MASK_RST}};
      tmr_a_req_flag_reg <= `IRQC_FLAG_RST;
      tmr_a_req_mask_reg <= `IRQC_MASK_RST;
      tmr_b_req_flag_reg <= `IRQC_FLAG_RST;
      tmr_b_req_mask_reg <= `IRQC_MASK_RST;
      tmr_c_req_flag_reg <= `IRQC_FLAG_RST;
      tmr_c_req_mask_reg <= `IRQC_MASK_RST;
      tmr_d_req_flag_reg <= `IRQC_FLAG_RST;
      tmr_d_req_mask_reg <= `IRQC_MASK_RST;
      serial_req_flag_reg <= `IRQC_FLAG_RST;
      serial_req_mask_reg <= `IRQC_MASK_RST;
      converter_req_flag_reg <= `IRQC_FLAG_RST;
      converter_req_mask_reg <= `IRQC_MASK_RST;
      edge_select_first_reg <= `IRQC_EDGE_RST;
    end
    else
    begin
      if (i_irq_taken)
        gate_reg <= 1'b0;
      else if (i_irq_return)
        gate_reg <= 1'b1;
      else if (wr0)
        gate_reg <= i_wdata[`IRQC_BIT_GATE];
      ext_req_flags_reg[0] <= flag_upd(ext_req_flags_reg[0], set_e0, wr0,
        i_wdata[`IRQC_BIT_F0]);
      ext_req_flags_reg[1] <= flag_upd(ext_req_flags_reg[1], set_e1, wr1,
        i_wdata[`IRQC_BIT_F1]);
      ext_req_flags_reg[2] <= flag_upd(ext_req_flags_reg[2], set_e2, wr22,
        i_wdata[`IRQC_BIT_F2]);
      ext_req_flags_reg[3] <= flag_upd(ext_req_flags_reg[3], set_e3, wr22,
        i_wdata[`IRQC_BIT_F3]);
      tmr_a_req_flag_reg <= flag_upd(tmr_a_req_flag_reg, i_tmr_a_ovf, wr1,
        i_wdata[`IRQC_BIT_FTA]);
      tmr_b_req_flag_reg <= flag_upd(tmr_b_req_flag_reg, i_tmr_b_ovf, wr2,
        i_wdata[`IRQC_BIT_FTB]);
      tmr_c_req_flag_reg <= flag_upd(tmr_c_req_flag_reg, i_tmr_c_ovf, wr2,
        i_wdata[`IRQC_BIT_FTC]);
      tmr_d_req_flag_reg <= flag_upd(tmr_d_req_flag_reg, set_td, wr3,
        i_wdata[`IRQC_BIT_FTD]);
      converter_req_flag_reg <= flag_upd(converter_req_flag_reg, i_converter_done, wr3,
        i_wdata[`IRQC_BIT_FAD]);
      serial_req_flag_reg <= flag_upd(serial_req_flag_reg, set_s, wr23,
        i_wdata[`IRQC_BIT_FS]);
      if (wr0)
        ext_req_masks_reg[0] <= i_wdata[`IRQC_BIT_M0];
      if (wr1)
      begin
        ext_req_masks_reg[1] <= i_wdata[`IRQC_BIT_M1];
        tmr_a_req_mask_reg <= i_wdata[`IRQC_BIT_MTA];
      end
      if (wr2)
      begin
        tmr_b_req_mask_reg <= i_wdata[`IRQC_BIT_MTB];
        tmr_c_req_mask_reg <= i_wdata[`IRQC_BIT_MTC];
      end
      if (wr3)
      begin
        tmr_d_req_mask_reg <= i_wdata[`IRQC_BIT_MTD];
        converter_req_mask_reg <= i_wdata[`IRQC_BIT_MAD];
      end
      if (wr22)
      begin
        ext_req_masks_reg[2] <= i_wdata[`IRQC_BIT_M2];
        ext_req_masks_reg[3] <= i_wdata[`IRQC_BIT_M3];
      end
      if (wr23)
        serial_req_mask_reg <= i_wdata[`IRQC_BIT_MS];
      if (wr26)
        edge_select_first_reg <= i_wdata;
    end
  end

  // ==========================================================
  // Request groups and priority
  wire [3:0] ext_live = ext_req_flags_reg & ~ext_req_masks_reg;
  assign group_req[0] = ext_live[0];
  assign group_req[1] = ext_live[1];
  assign group_req[2] = req_live(tmr_a_req_flag_reg, tmr_a_req_mask_reg);
  assign group_req[3] = req_live(tmr_b_req_flag_reg, tmr_b_req_mask_reg) |
    ext_live[2];
  assign group_req[4] = req_live(tmr_c_req_flag_reg, tmr_c_req_mask_reg) |
    ext_live[3];
  assign group_req[5] = req_live(tmr_d_req_flag_reg, tmr_d_req_mask_reg);
  assign group_req[6] = req_live(converter_req_flag_reg, converter_req_mask_reg) |
    req_live(serial_req_flag_reg, serial_req_mask_reg);

  // Request to the sequencer only while the global gate is open
  wire req_next = gate_reg & (|group_req);

  irqc_prio u_prio
  (
    .i_group_req(group_req),
    .o_vector(vector_next)
  );

  // ==========================================================
  // Read mux; edge select locations are write-only and read zero
  always @*
  begin
    case (i_addr)
      `IRQC_ADDR_CTL0: rdata_next = {ext_req_masks_reg[0], ext_req_flags_reg[0], 1'b0, gate_reg};
      `IRQC_ADDR_TMR_A: rdata_next = {tmr_a_req_mask_reg, tmr_a_req_flag_reg,
        ext_req_masks_reg[1], ext_req_flags_reg[1]};
      `IRQC_ADDR_TMR_BC: rdata_next = {tmr_c_req_mask_reg, tmr_c_req_flag_reg,
        tmr_b_req_mask_reg, tmr_b_req_flag_reg};
      `IRQC_ADDR_TMR_D_CONV: rdata_next = {converter_req_mask_reg, converter_req_flag_reg,
        tmr_d_req_mask_reg, tmr_d_req_flag_reg};
      `IRQC_ADDR_CTL22: rdata_next = {ext_req_masks_reg[3], ext_req_flags_reg[3],
        ext_req_masks_reg[2], ext_req_flags_reg[2]};
      `IRQC_ADDR_SERIAL: rdata_next = {serial_req_mask_reg, serial_req_flag_reg, 2'b00};
      default: rdata_next = 4'h0;
    endcase
  end

  // ==========================================================
  // Registered outputs
  always @(posedge i_clock or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_rdata <= 4'h0;
      o_irq_req <= 1'b0;
      o_irq_vector <= `IRQC_VEC_NONE;
    end
    else
    begin
      o_rdata <= rdata_next;
      o_irq_req <= req_next;
      o_irq_vector <= vector_next;
    end
  end

endmodule

// ==== test/irqc_checker.sv ====
// Port checks for the interrupt flag and mask block
`timescale 1ns/1ns
module irqc_checker (
  input wire i_clock,                // System clock
  input wire i_reset_n,              // Reset, active low
  input wire i_tmr_a_ovf,            // Timer A overflow
  input wire i_serial_done,          // Serial done
  input wire i_serial_suspend,       // Serial suspend
  input wire i_converter_done,       // Conversion done
  input wire i_irq_taken,            // Interrupt accepted
  input wire i_irq_return,           // Interrupt return
  input wire [9:0] i_addr,           // Nibble address
  input wire i_wr,                   // Write strobe
  input wire [3:0] i_wdata,          // Write data
  input wire [3:0] o_rdata,          // Read data
  input wire o_irq_req,              // Request to CPU
  input wire [15:0] o_irq_vector     // Vector
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Request and vector
  a_reset_quiet: assert property ($rose(i_reset_n) |-> !o_irq_req && o_irq_vector == 16'h0000)
    else $error("request or vector not clear after reset");
  a_taken_gate_off: assert property (i_irq_taken ##1 (!i_irq_return && !i_wr) [*2] |-> !o_irq_req)
    else $error("request stays after interrupt taken");
  a_req_has_vec: assert property (o_irq_req |-> o_irq_vector != 16'h0000)
    else $error("request without vector");
  a_vec_legal: assert property (o_irq_vector[15:4] == 12'h000 && !o_irq_vector[0])
    else $error("vector outside table");
  // ==========================================================
  // Register port
  a_unmapped_zero: assert property (((i_addr > 10'h003 && i_addr < 10'h022) || i_addr > 10'h023)
    |=> o_rdata == 4'h0)
    else $error("unmapped or write-only place reads nonzero");
  a_serial_pad: assert property (i_addr == 10'h023 |=> o_rdata[1:0] == 2'h0)
    else $error("serial nibble low bits nonzero");
  a_tma_sets: assert property (i_tmr_a_ovf ##1 i_addr == 10'h001 |=> o_rdata[2])
    else $error("timer A flag not set");
  a_conv_sets: assert property (i_converter_done ##1 i_addr == 10'h003 |=> o_rdata[2])
    else $error("converter flag not set");
  a_serial_sets: assert property ((i_serial_done || i_serial_suspend) ##1 i_addr == 10'h023
    |=> o_rdata[2])
    else $error("serial flag not set");
  a_write_clears: assert property ((i_wr && i_addr == 10'h001 && !i_wdata[2] && !i_tmr_a_ovf)
    ##1 i_addr == 10'h001 |=> !o_rdata[2])
    else $error("timer A flag survives clearing write");
endmodule

bind irqc_top irqc_checker chk (.i_clock, .i_reset_n, .i_tmr_a_ovf, .i_serial_done,
  .i_serial_suspend, .i_converter_done, .i_irq_taken, .i_irq_return, .i_addr, .i_wr,
  .i_wdata, .o_rdata, .o_irq_req, .o_irq_vector);

// ==== test/irqc_src_model.sv ====
// Event sources and sequencer strobes on the far side of the block
`timescale 1ns/1ns
module irqc_src_model (
  input wire logic i_clock,   // System clock
  output logic [8:0] o_pulse  // One-cycle strobes
);
  initial o_pulse = 9'h000;
  // Waits d falling edges, then raises the strobes for one cycle
  task automatic send(input logic [8:0] v, input int d);
    repeat (d) @(negedge i_clock);
    o_pulse = v;
    @(negedge i_clock);
    o_pulse = 9'h000;
  endtask
endmodule

// ==== test/tb_irqc_top.sv ====
// Self-checking bench for the interrupt flag and mask block
`timescale 1ns/1ns
module tb_irqc_top;
  typedef struct {logic [8:0] f; int d; logic [9:0] a; logic [3:0] r; logic [15:0] v;} irqc_row_t;
  logic i_clock = 1'h0;
  logic i_reset_n = 1'h0;
  logic i_ext_line_first_n = 1'h1;
  logic i_ext_line_second_n = 1'h1;
  logic i_ext_line_third = 1'h0;
  logic i_ext_line_fourth = 1'h0;
  logic i_tmr_d_event_input = 1'h0;
  logic i_tmr_d_capture_on = 1'h0;
  logic i_wr = 1'h0;
  logic [9:0] i_addr = 10'h000;
  logic [3:0] i_wdata = 4'h0;
  logic [3:0] o_rdata;
  logic o_irq_req;
  logic [15:0] o_irq_vector;
  logic [8:0] pulse;
  int fails = 0;
  int compares = 0;
  logic [9:0] ra [10] = '{10'h000, 10'h001, 10'h002, 10'h003, 10'h022, 10'h023, 10'h026,
    10'h027, 10'h010, 10'h3ff};
  logic [3:0] re [10] = '{4'h8, 4'ha, 4'ha, 4'ha, 4'ha, 4'h8, 4'h0, 4'h0, 4'h0, 4'h0};
  irqc_row_t rows [7] = '{
    '{9'h001, 0, 10'h001, 4'h4, 16'h0006},
    '{9'h002, 3, 10'h002, 4'h1, 16'h0008},
    '{9'h004, 0, 10'h002, 4'h4, 16'h000a},
    '{9'h008, 3, 10'h003, 4'h1, 16'h000c},
    '{9'h010, 0, 10'h023, 4'h4, 16'h000e},
    '{9'h020, 2, 10'h023, 4'h4, 16'h000e},
    '{9'h040, 0, 10'h003, 4'h4, 16'h000e}};

  irqc_src_model src (.i_clock, .o_pulse(pulse));
  irqc_top DUT (.i_clock, .i_reset_n, .i_ext_line_first_n, .i_ext_line_second_n,
    .i_ext_line_third, .i_ext_line_fourth, .i_tmr_d_event_input, .i_tmr_d_capture_on,
    .i_tmr_a_ovf(pulse[0]), .i_tmr_b_ovf(pulse[1]), .i_tmr_c_ovf(pulse[2]),
    .i_tmr_d_ovf(pulse[3]), .i_serial_done(pulse[4]), .i_serial_suspend(pulse[5]),
    .i_converter_done(pulse[6]), .i_irq_taken(pulse[7]), .i_irq_return(pulse[8]),
    .i_addr, .i_wr, .i_wdata, .o_rdata, .o_irq_req, .o_irq_vector);

  initial
  begin
    forever #5 i_clock = ~i_clock;
  end

  task automatic step(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic err(input string m);
    fails++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    @(negedge i_clock);
    i_addr = a;
    i_wdata = d;
    i_wr = 1'h1;
    @(negedge i_clock);
    i_wr = 1'h0;
  endtask
  task automatic chk_rd(input logic [9:0] a, input logic [3:0] e);
    @(negedge i_clock);
    i_addr = a;
    @(negedge i_clock);
    compares++;
    if (o_rdata !== e) err($sformatf("read %h got %h want %h", a, o_rdata, e));
  endtask
  task automatic chk_irq(input logic r, input logic [15:0] v);
    compares++;
    if ({o_irq_req, o_irq_vector} !== {r, v})
      err($sformatf("request %b vector %h want %b %h", o_irq_req, o_irq_vector, r, v));
  endtask
  task automatic print_verdict;
    $display("%0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    err("run too long");
    print_verdict();
  end

  initial
  begin
    step(5);
    i_reset_n = 1'h1;
    chk_irq(1'h0, 16'h0000);
    foreach (ra[k]) chk_rd(ra[k], re[k]);
    $display("reset values done");
    foreach (ra[k]) if (k < 6) wr(ra[k], k == 0 ? 4'h1 : 4'h0);
    foreach (rows[k])
    begin
      i_addr = rows[k].a;
      src.send(rows[k].f, rows[k].d);
      step(2);
      chk_irq(1'h1, rows[k].v);
      chk_rd(rows[k].a, rows[k].r);
      wr(rows[k].a, 4'h0);
      step(2);
      chk_irq(1'h0, 16'h0000);
    end
    $display("event rows done");
    wr(10'h022, 4'h2);
    i_ext_line_third = 1'h1;
    i_ext_line_fourth = 1'h1;
    step(8);
    i_ext_line_third = 1'h0;
    i_ext_line_fourth = 1'h0;
    step(8);
    chk_rd(10'h022, 4'h2);
    wr(10'h026, 4'h5);
    chk_rd(10'h026, 4'h0);
    i_ext_line_third = 1'h1;
    i_ext_line_fourth = 1'h1;
    step(8);
    chk_rd(10'h022, 4'h2);
    i_ext_line_third = 1'h0;
    i_ext_line_fourth = 1'h0;
    step(8);
    chk_rd(10'h022, 4'h7);
    chk_irq(1'h1, 16'h000a);
    wr(10'h022, 4'h0);
    i_ext_line_first_n = 1'h0;
    step(8);
    chk_rd(10'h000, 4'h5);
    chk_irq(1'h1, 16'h0002);
    wr(10'h000, 4'h1);
    i_ext_line_second_n = 1'h0;
    step(8);
    chk_rd(10'h001, 4'h1);
    chk_irq(1'h1, 16'h0004);
    wr(10'h001, 4'h0);
    i_ext_line_first_n = 1'h1;
    i_ext_line_second_n = 1'h1;
    step(8);
    chk_irq(1'h0, 16'h0000);
    wr(10'h010, 4'hf);
    chk_rd(10'h010, 4'h0);
    $display("external inputs done");
    i_tmr_d_event_input = 1'h1;
    step(8);
    chk_rd(10'h003, 4'h0);
    i_tmr_d_capture_on = 1'h1;
    i_tmr_d_event_input = 1'h0;
    step(8);
    chk_rd(10'h003, 4'h1);
    wr(10'h003, 4'h0);
    $display("capture done");
    wr(10'h001, 4'h8);
    src.send(9'h001, 0);
    step(2);
    chk_irq(1'h0, 16'h0000);
    chk_rd(10'h001, 4'hc);
    wr(10'h001, 4'h4);
    step(2);
    chk_irq(1'h1, 16'h0006);
    wr(10'h000, 4'h0);
    src.send(9'h040, 0);
    step(2);
    chk_irq(1'h0, 16'h0006);
    src.send(9'h100, 1);
    step(2);
    chk_irq(1'h1, 16'h0006);
    src.send(9'h080, 0);
    step(2);
    chk_irq(1'h0, 16'h0006);
    src.send(9'h100, 0);
    wr(10'h001, 4'h0);
    step(2);
    chk_irq(1'h1, 16'h000e);
    $display("mask and gate done");
    wr(10'h002, 4'ha);
    wr(10'h003, 4'ha);
    wr(10'h023, 4'h8);
    src.send(9'h05e, 0);
    step(2);
    chk_irq(1'h0, 16'h0000);
    chk_rd(10'h002, 4'hf);
    chk_rd(10'h003, 4'hf);
    chk_rd(10'h023, 4'hc);
    $display("source masks done");
    i_reset_n = 1'h0;
    step(2);
    chk_irq(1'h0, 16'h0000);
    i_reset_n = 1'h1;
    chk_rd(10'h003, 4'ha);
    $display("second reset done");
    print_verdict();
  end
endmodule
